// file: logic/csw_pkg.sv
/*
 * constants for the channel status word register bank: register offsets,
 * status bit positions, reset values and field masks.
 * assumes a 32-bit apb register bus with an 8-bit byte address.
 */
package csw_pkg;

  // ------------------------------------------------------------
  // bus geometry
  // ------------------------------------------------------------
  localparam int          CSW_AW         = 8;
  localparam int          CSW_DW         = 32;

  // ------------------------------------------------------------
  // register byte offsets
  // ------------------------------------------------------------
  localparam logic [7:0]  ADDR_STATUS    = 8'h00;
  localparam logic [7:0]  ADDR_CTRL      = 8'h04;
  localparam logic [7:0]  ADDR_IRQ_STAT  = 8'h08;
  localparam logic [7:0]  ADDR_IRQ_MASK  = 8'h0C;

  // ------------------------------------------------------------
  // status word bit positions
  // ------------------------------------------------------------
  localparam int          P_ALARM3       = 14;
  localparam int          P_EVENT1       = 16;
  localparam int          P_EVENT2       = 17;
  localparam int          P_WRITE_MODE   = 20;
  localparam int          P_NV_DIFFERS   = 21;
  localparam int          P_SELF_TUNE    = 22;
  localparam int          P_AUTOTUNE     = 23;
  localparam int          P_STOPPED      = 24;
  localparam int          P_COMM_WR_EN   = 25;
  localparam int          P_MANUAL       = 26;
  localparam int          P_REMOTE_SP    = 27;
  localparam int          P_SP_RAMP      = 30;

  // ------------------------------------------------------------
  // masks and reset values
  // ------------------------------------------------------------
  localparam logic [31:0] STAT_USED_MASK = 32'h4FF3_4000;
  localparam logic [31:0] STAT_RST       = 32'h0200_0000;
  localparam logic [31:0] CTRL_MASK      = 32'h0000_0001;
  localparam logic [31:0] CTRL_RST       = 32'h0000_0000;
  localparam logic [31:0] IRQ_STAT_RST   = 32'h0000_0000;
  localparam logic [31:0] IRQ_MASK_RST   = 32'h0000_0000;
  localparam int          CTRL_RAM_WRITE = 0;

endpackage

// file: logic/csw_bus_if.sv
/*
 * internal register access carrier between the apb front end and the
 * register bank. strobes are single-cycle and synchronous to the bank clock.
 */
`timescale 1ns/1ps
interface csw_bus_if;
  logic        rd_stb;
  logic        wr_stb;
  logic        write;
  logic [7:0]  addr;
  logic [31:0] wdata;
  logic [31:0] rdata;
  logic        err;

  modport apb  (output rd_stb, output wr_stb, output write, output addr, output wdata,
                input rdata, input err);
  modport regs (input rd_stb, input wr_stb, input write, input addr, input wdata,
                output rdata, output err);
endinterface

// file: logic/csw_apb.sv
/*
 * apb slave front end: turns apb phases into read and write strobes and
 * captures read data and error in the setup phase.
 * assumes a well-behaved apb master; always ready, zero wait states.
 */
`timescale 1ns/1ps
module csw_apb (
  input  wire logic        i_clk,
  input  wire logic        i_rst_b,
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [7:0]  i_paddr,
  input  wire logic [31:0] i_pwdata,
  output logic             o_pready,
  output logic [31:0]      o_prdata,
  output logic             o_pslverr,
  csw_bus_if.apb           bus
);

  logic        setup;
  logic        access;
  logic [31:0] prdata_q;
  logic        err_q;

  // ------------------------------------------------------------
  // phase decode
  // ------------------------------------------------------------
  assign setup       = i_psel & ~i_penable;
  assign access      = i_psel & i_penable;
  assign bus.rd_stb  = setup & ~i_pwrite;
  assign bus.wr_stb  = access & i_pwrite;
  assign bus.write   = i_pwrite;
  assign bus.addr    = i_paddr;
  assign bus.wdata   = i_pwdata;
  assign o_pready    = 1'b1;
  assign o_prdata    = prdata_q;
  assign o_pslverr   = err_q & access;

  // capture answer in setup phase, hold through access
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      prdata_q <= 32'h0000_0000;
      err_q    <= 1'b0;
    end else if (setup) begin
      prdata_q <= bus.rd_stb ? bus.rdata : 32'h0000_0000;
      err_q    <= bus.err;
    end
  end

endmodule

// file: logic/csw_irq.sv
/*
 * sticky event flags with write-one-to-clear, a mask of the same layout,
 * and one level interrupt. a set in the clearing cycle wins.
 */
`timescale 1ns/1ps
module csw_irq #(
  parameter int W = 32
) (
  input  wire logic         i_clk,
  input  wire logic         i_rst_b,
  input  wire logic [W-1:0] i_evt,
  input  wire logic         i_clr_stb,
  input  wire logic [W-1:0] i_clr,
  input  wire logic         i_mask_stb,
  input  wire logic [W-1:0] i_mask,
  output logic [W-1:0]      o_status,
  output logic [W-1:0]      o_mask,
  output logic              o_irq
);

  logic [W-1:0] status_q;
  logic [W-1:0] status_d;
  logic [W-1:0] mask_q;

  // set beats clear
  assign status_d = (status_q & ~(i_clr_stb ? i_clr : '0)) | i_evt;

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      status_q <= csw_pkg::IRQ_STAT_RST[W-1:0];
      mask_q   <= csw_pkg::IRQ_MASK_RST[W-1:0];
    end else begin
      status_q <= status_d;
      if (i_mask_stb) begin
        mask_q <= i_mask;
      end
    end
  end

  assign o_status = status_q;
  assign o_mask   = mask_q;
  assign o_irq    = |(status_q & mask_q);

  // a flagged event survives a clear written in the same cycle
  AST_SET_WINS: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    (i_evt != '0) |=> ((status_q & $past(i_evt)) == $past(i_evt)))
    else $error("event flag lost to a same-cycle clear");

endmodule

// file: logic/csw_top.sv
/*
 * channel status word register bank, upper half (bits 14..31).
 * samples the control core's status levels every clock into a read-only
 * word, flags every change as a sticky interrupt event, and serves it all
 * over apb. assumes core status inputs are synchronous to i_clk.
 */
// Functional notes
// - bit 14 follows alarm output 3
// - bit 16 follows event input 1
// - bit 17 follows event input 2
// - bit 20 is one in ram-only write mode
// - bit 21 is one when ram differs from nonvolatile
// - bit 22 is one while self-tuning runs
// - bit 23 is one while autotuning runs
// - bit 24 is one while channel stopped
// - bit 25 always reads one
// - bit 26 is one in manual mode
// - bit 27 is one for remote setpoint
// - bit 30 is one while setpoint ramps
`timescale 1ns/1ps
module csw_top (
  input  wire logic        i_clk,
  input  wire logic        i_rst_b,
  // apb slave
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [7:0]  i_paddr,
  input  wire logic [31:0] i_pwdata,
  output logic             o_pready,
  output logic [31:0]      o_prdata,
  output logic             o_pslverr,
  // channel state from the control core
  input  wire logic        i_alarm3_on,
  input  wire logic        i_event1_on,
  input  wire logic        i_event2_on,
  input  wire logic        i_nv_differs,
  input  wire logic        i_self_tuning_active,
  input  wire logic        i_autotune_active,
  input  wire logic        i_stopped,
  input  wire logic        i_manual,
  input  wire logic        i_remote_setpoint,
  input  wire logic        i_setpoint_ramp,
  // outputs
  output logic             o_ram_write_mode,
  output logic [31:0]      o_status_word,
  output logic             o_irq
);

  // ------------------------------------------------------------
  // reset release
  // ------------------------------------------------------------
  logic rst_meta_q;
  logic rst_b_q;

  // async assert, two-flop synchronous release
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rst_meta_q <= 1'b0;
      rst_b_q    <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_b_q    <= rst_meta_q;
    end
  end

  // ------------------------------------------------------------
  // declarations
  // ------------------------------------------------------------
  csw_bus_if   bus ();
  logic [31:0] stat_d;
  logic [31:0] stat_q;
  logic [31:0] ctrl_q;
  logic        primed_q;
  logic [31:0] evt;
  logic [31:0] irq_stat;
  logic [31:0] irq_mask;
  logic        sel_stat;
  logic        sel_ctrl;
  logic        sel_istat;
  logic        sel_imask;
  logic        hit;
  logic        wr_ctrl;
  logic        wr_istat;
  logic        wr_imask;
  logic        ram_write;

  // ------------------------------------------------------------
  // status word assembly
  // ------------------------------------------------------------
  assign ram_write = ctrl_q[csw_pkg::CTRL_RAM_WRITE];

  // next status word from core levels; unused bits stay zero
  always_comb begin
    stat_d                        = 32'h0000_0000;
    stat_d[csw_pkg::P_ALARM3]     = i_alarm3_on;
    stat_d[csw_pkg::P_EVENT1]     = i_event1_on;
    stat_d[csw_pkg::P_EVENT2]     = i_event2_on;
    stat_d[csw_pkg::P_WRITE_MODE] = ram_write;
    stat_d[csw_pkg::P_NV_DIFFERS] = i_nv_differs;
    stat_d[csw_pkg::P_SELF_TUNE]  = i_self_tuning_active;
    stat_d[csw_pkg::P_AUTOTUNE]   = i_autotune_active;
    stat_d[csw_pkg::P_STOPPED]    = i_stopped;
    stat_d[csw_pkg::P_COMM_WR_EN] = 1'b1;
    stat_d[csw_pkg::P_MANUAL]     = i_manual;
    stat_d[csw_pkg::P_REMOTE_SP]  = i_remote_setpoint;
    stat_d[csw_pkg::P_SP_RAMP]    = i_setpoint_ramp;
  end

  // sample every clock; the bus never writes this word
  always_ff @(posedge i_clk or negedge rst_b_q) begin
    if (!rst_b_q) begin
      stat_q   <= csw_pkg::STAT_RST;
      primed_q <= 1'b0;
    end else begin
      stat_q   <= stat_d & csw_pkg::STAT_USED_MASK;
      primed_q <= 1'b1;
    end
  end

  // change of any used bit is an event, once the word holds real data
  assign evt = primed_q ? ((stat_d ^ stat_q) & csw_pkg::STAT_USED_MASK) : 32'h0000_0000;

  // ------------------------------------------------------------
  // register decode
  // ------------------------------------------------------------
  assign sel_stat  = (bus.addr == csw_pkg::ADDR_STATUS);
  assign sel_ctrl  = (bus.addr == csw_pkg::ADDR_CTRL);
  assign sel_istat = (bus.addr == csw_pkg::ADDR_IRQ_STAT);
  assign sel_imask = (bus.addr == csw_pkg::ADDR_IRQ_MASK);
  assign hit       = sel_stat | sel_ctrl | sel_istat | sel_imask;
  assign wr_ctrl   = bus.wr_stb & sel_ctrl;
  assign wr_istat  = bus.wr_stb & sel_istat;
  assign wr_imask  = bus.wr_stb & sel_imask;

  // unmapped address or write to the read-only word is an error
  assign bus.err   = ~hit | (bus.write & sel_stat);

  // read mux
  assign bus.rdata = sel_stat  ? stat_q   :
                     sel_ctrl  ? ctrl_q   :
                     sel_istat ? irq_stat :
                     sel_imask ? irq_mask : 32'h0000_0000;

  // ------------------------------------------------------------
  // control register
  // ------------------------------------------------------------
  // write mode select: backup (0) or ram only (1)
  always_ff @(posedge i_clk or negedge rst_b_q) begin
    if (!rst_b_q) begin
      ctrl_q <= csw_pkg::CTRL_RST;
    end else if (wr_ctrl) begin
      ctrl_q <= bus.wdata & csw_pkg::CTRL_MASK;
    end
  end

  // ------------------------------------------------------------
  // submodules
  // ------------------------------------------------------------
  csw_apb u_apb (
    .i_clk     (i_clk),
    .i_rst_b   (rst_b_q),
    .i_psel    (i_psel),
    .i_penable (i_penable),
    .i_pwrite  (i_pwrite),
    .i_paddr   (i_paddr),
    .i_pwdata  (i_pwdata),
    .o_pready  (o_pready),
    .o_prdata  (o_prdata),
    .o_pslverr (o_pslverr),
    .bus       (bus.apb)
  );

  csw_irq #(
    .W (32)
  ) u_irq (
    .i_clk      (i_clk),
    .i_rst_b    (rst_b_q),
    .i_evt      (evt),
    .i_clr_stb  (wr_istat),
    .i_clr      (bus.wdata),
    .i_mask_stb (wr_imask),
    .i_mask     (bus.wdata & csw_pkg::STAT_USED_MASK),
    .o_status   (irq_stat),
    .o_mask     (irq_mask),
    .o_irq      (o_irq)
  );

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  assign o_status_word    = stat_q;
  assign o_ram_write_mode = ram_write;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!rst_b_q);

  // read request to the status word in setup phase
  sequence s_rd_status;
    i_psel && !i_penable && !i_pwrite && (i_paddr == csw_pkg::ADDR_STATUS);
  endsequence

  // write request to the status word completing in access phase
  sequence s_wr_status;
    i_psel && i_penable && i_pwrite && (i_paddr == csw_pkg::ADDR_STATUS);
  endsequence

  // primed_q keeps every attempt of the checks it gates off the edge at which the word leaves reset
  AST_ALARM3: assert property (primed_q |=> stat_q[csw_pkg::P_ALARM3] == $past(i_alarm3_on))
    else $error("alarm 3 bit does not follow its output");

  AST_EVENT1: assert property (primed_q && $rose(i_event1_on) |=> stat_q[csw_pkg::P_EVENT1])
    else $error("event 1 bit missed a rising input");

  AST_EVENT2: assert property (!i_event2_on |=> !stat_q[csw_pkg::P_EVENT2])
    else $error("event 2 bit set while input off");

  AST_WRMODE: assert property (wr_ctrl |=> ##1 stat_q[csw_pkg::P_WRITE_MODE] == $past(bus.wdata[0], 2))
    else $error("write mode bit does not follow control write");

  AST_NVDIFF: assert property (primed_q |=> stat_q[csw_pkg::P_NV_DIFFERS] == $past(i_nv_differs))
    else $error("nonvolatile compare bit wrong");

  AST_SELFTUNE: assert property ($fell(i_self_tuning_active) |=> !stat_q[csw_pkg::P_SELF_TUNE])
    else $error("self-tuning bit stayed set");

  AST_AUTOTUNE: assert property ((primed_q && i_autotune_active) ##1 i_autotune_active |-> stat_q[csw_pkg::P_AUTOTUNE])
    else $error("autotune bit clear while running");

  AST_STOPPED: assert property (primed_q |=> stat_q[csw_pkg::P_STOPPED] == $past(i_stopped))
    else $error("run/stop bit wrong");

  AST_COMMWR: assert property (stat_q[csw_pkg::P_COMM_WR_EN] && o_status_word[csw_pkg::P_COMM_WR_EN])
    else $error("communications write bit not one");

  AST_MANUAL: assert property (primed_q |=> stat_q[csw_pkg::P_MANUAL] == $past(i_manual))
    else $error("auto/manual bit wrong");

  AST_REMOTE: assert property (primed_q && $changed(i_remote_setpoint) |=> $changed(stat_q[csw_pkg::P_REMOTE_SP]))
    else $error("setpoint mode bit did not change");

  AST_RAMP: assert property (primed_q |=> stat_q[csw_pkg::P_SP_RAMP] == $past(i_setpoint_ramp))
    else $error("setpoint ramp bit wrong");

  AST_UNUSED: assert property ((stat_q & ~csw_pkg::STAT_USED_MASK) == 32'h0000_0000)
    else $error("unused status bit set");

  AST_RO_WRITE: assert property (s_wr_status |-> o_pslverr ##1 stat_q == $past(stat_d))
    else $error("status word write not refused");

  AST_READ: assert property (s_rd_status ##1 (i_psel && i_penable) |-> o_pready && o_prdata == $past(stat_q))
    else $error("status read returned wrong data");

  AST_IRQ_SET: assert property ((evt & irq_mask) != 32'h0000_0000 |=> o_irq)
    else $error("unmasked event did not raise interrupt");

endmodule

// file: verification/csw_top_test.sv
/*
 * self-checking bench for the channel status word bank: drives apb and the
 * core status levels, checks the status word, control, refusals, interrupts.
 * assumes csw_top and csw_pkg compiled first; 10 MHz single clock.
 */
`timescale 1ns/1ps
module channel_status_word_upper_test;
  // ------------------------------------------------------------
  // signals
  // ------------------------------------------------------------
  logic        i_clk;
  logic        i_rst_b;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic        o_pready;
  logic [31:0] o_prdata;
  logic        o_pslverr;
  logic [9:0]  cin;
  logic        o_ram_write_mode;
  logic [31:0] o_status_word;
  logic        o_irq;
  logic [31:0] rd;
  logic        er;
  logic        wm;
  int          error_cnt;
  int          num_checks;
  integer      seed;

  csw_top dut (
    .i_clk                (i_clk),
    .i_rst_b              (i_rst_b),
    .i_psel               (psel),
    .i_penable            (penable),
    .i_pwrite             (pwrite),
    .i_paddr              (paddr),
    .i_pwdata             (pwdata),
    .o_pready             (o_pready),
    .o_prdata             (o_prdata),
    .o_pslverr            (o_pslverr),
    .i_alarm3_on          (cin[0]),
    .i_event1_on          (cin[1]),
    .i_event2_on          (cin[2]),
    .i_nv_differs         (cin[3]),
    .i_self_tuning_active (cin[4]),
    .i_autotune_active    (cin[5]),
    .i_stopped            (cin[6]),
    .i_manual             (cin[7]),
    .i_remote_setpoint    (cin[8]),
    .i_setpoint_ramp      (cin[9]),
    .o_ram_write_mode     (o_ram_write_mode),
    .o_status_word        (o_status_word),
    .o_irq                (o_irq)
  );

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  // clock, 100 ns period
  initial begin
    i_clk = 1'b0;
    forever #50 i_clk = ~i_clk;
  end

  // expected status word from core levels and write mode
  function automatic logic [31:0] exp_stat(input logic [9:0] c, input logic m);
    logic [31:0] s;
    s     = 32'h0000_0000;
    s[14] = c[0];
    s[16] = c[1];
    s[17] = c[2];
    s[20] = m;
    s[21] = c[3];
    s[22] = c[4];
    s[23] = c[5];
    s[24] = c[6];
    s[25] = 1'b1;
    s[26] = c[7];
    s[27] = c[8];
    s[30] = c[9];
    return s;
  endfunction

  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string msg);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: %s got %h expected %h", $time, msg, got, exp);
    end
  endtask

  // one apb transfer; waits for pready, takes data at that edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge i_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge i_clk);
    penable <= 1'b1;
    do begin
      @(posedge i_clk);
      n++;
    end while (o_pready !== 1'b1 && n < 20);
    rd      = o_prdata;
    er      = o_pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) check(32'h1, 32'h0, "pready timeout");
  endtask

  task automatic summarize;
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // watchdog, far beyond the few hundred cycles the tests need
  initial begin
    #2_000_000;
    error_cnt++;
    $display("wrong value at %0t: run did not finish", $time);
    summarize();
  end

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    seed = 32'h88f9482e;
    error_cnt = 0;
    num_checks = 0;
    i_rst_b = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    cin = 10'h000;
    wm = 1'b0;
    repeat (3) @(posedge i_clk);
    i_rst_b <= 1'b1;
    repeat (4) @(posedge i_clk);
    // reset values of every register
    apb(1'b0, 8'h00, 32'h0); check(rd, 32'h0200_0000, "status reset");
    apb(1'b0, 8'h04, 32'h0); check(rd, 32'h0000_0000, "ctrl reset");
    apb(1'b0, 8'h08, 32'h0); check(rd, 32'h0000_0000, "irq stat reset");
    apb(1'b0, 8'h0C, 32'h0); check(rd, 32'h0000_0000, "irq mask reset");
    $display("test reset values done");
    // ram-only write mode reaches bit 20
    apb(1'b1, 8'h04, 32'hFFFF_FFFF);
    wm = 1'b1;
    apb(1'b0, 8'h04, 32'h0); check(rd, 32'h0000_0001, "ctrl readback");
    repeat (2) @(posedge i_clk);
    #1 check({31'h0, o_ram_write_mode}, 32'h1, "write mode out");
    check(o_status_word, exp_stat(cin, wm), "bit 20 set");
    $display("test write mode done");
    // random and corner core levels
    for (int i = 0; i < 24; i++) begin
      @(posedge i_clk);
      cin <= (i == 0) ? 10'h3FF : (i == 1) ? 10'h000 : 10'($random(seed));
      if (i == 12) begin
        apb(1'b1, 8'h04, 32'h0000_0000);
        wm = 1'b0;
      end
      repeat (3) @(posedge i_clk);
      #1 check(o_status_word, exp_stat(cin, wm), "status out");
      apb(1'b0, 8'h00, 32'h0); check(rd, exp_stat(cin, wm), "status read");
      check({31'h0, er}, 32'h0, "status read err");
    end
    $display("test status levels done");
    // refused write to the status word and unmapped place
    apb(1'b1, 8'h00, 32'hFFFF_FFFF); check({31'h0, er}, 32'h1, "status write err");
    apb(1'b0, 8'h00, 32'h0); check(rd, exp_stat(cin, wm), "status after write");
    apb(1'b1, 8'h10, 32'hFFFF_FFFF); check({31'h0, er}, 32'h1, "unmapped write err");
    apb(1'b0, 8'h10, 32'h0); check(rd, 32'h0000_0000, "unmapped read");
    check({31'h0, er}, 32'h1, "unmapped read err");
    $display("test refusals done");
    // interrupt raise, mask, clear
    apb(1'b1, 8'h08, 32'hFFFF_FFFF);
    apb(1'b0, 8'h08, 32'h0); check(rd, 32'h0000_0000, "irq cleared");
    apb(1'b1, 8'h0C, 32'hFFFF_FFFF);
    apb(1'b0, 8'h0C, 32'h0); check(rd, 32'h4FF3_4000, "mask used bits");
    apb(1'b1, 8'h0C, 32'h0000_4000);
    #1 check({31'h0, o_irq}, 32'h0, "irq idle");
    @(posedge i_clk);
    cin <= cin ^ 10'h001;
    repeat (3) @(posedge i_clk);
    #1 check({31'h0, o_irq}, 32'h1, "irq on alarm3 change");
    @(posedge i_clk);
    cin <= cin ^ 10'h002;
    repeat (3) @(posedge i_clk);
    apb(1'b0, 8'h08, 32'h0); check(rd, 32'h0001_4000, "irq flags");
    apb(1'b1, 8'h08, 32'h0000_4000);
    apb(1'b0, 8'h08, 32'h0); check(rd, 32'h0001_0000, "w1c one bit");
    #1 check({31'h0, o_irq}, 32'h0, "masked flag no irq");
    // corner: alarm 3 changes in the very cycle its flag is cleared
    fork
      apb(1'b1, 8'h08, 32'h0000_4000);
      begin
        repeat (2) @(posedge i_clk);
        cin <= cin ^ 10'h001;
      end
    join
    apb(1'b0, 8'h08, 32'h0);
    check(rd, 32'h0001_4000, "set beats clear");
    #1 check({31'h0, o_irq}, 32'h1, "irq after set beats clear");
    $display("test interrupts done");
    // reset again in mid-run, with write mode and interrupt both active
    apb(1'b1, 8'h04, 32'h0000_0001);
    @(posedge i_clk);
    i_rst_b <= 1'b0;
    @(posedge i_clk);
    #1 check(o_status_word, 32'h0200_0000, "status in reset");
    check({30'h0, o_irq, o_ram_write_mode}, 32'h0, "irq and mode in reset");
    @(posedge i_clk);
    i_rst_b <= 1'b1;
    wm = 1'b0;
    repeat (4) @(posedge i_clk);
    apb(1'b0, 8'h08, 32'h0); check(rd, 32'h0000_0000, "irq stat after reset");
    apb(1'b0, 8'h0C, 32'h0);
    check(rd, 32'h0000_0000, "irq mask after reset");
    apb(1'b0, 8'h00, 32'h0);
    check(rd, exp_stat(cin, wm), "status after reset");
    $display("test second reset done");
    summarize();
  end
endmodule
